//--- rtl/emt_ext_mem_if.v
`timescale 1ns/1ps
`default_nettype none
`include "emt_consts.vh"

// Function
// RULE1: Mode 00 keeps every access on-chip.
// RULE2: Internal-only addresses alias modulo 4 KB.
// RULE3: 8-bit address is page byte plus R0/R1.
// RULE4: 16-bit address comes from data pointer.
// RULE5: Mode 01 splits space at 4 KB.
// RULE6: Mode 01 8-bit leaves upper byte undriven.
// RULE7: Split 16-bit drives all sixteen address lines.
// RULE8: Mode 10 drives upper byte from page.
// RULE9: Mode 11 sends everything off-chip.
// RULE10: Mode 11 8-bit ignores page, upper undriven.
// RULE11: Mode 11 16-bit drives full address.
// RULE12: Setup, strobe, hold fields in timing register.
// RULE13: Off-chip access lasts fields plus four clocks.
// RULE14: Multiplexed mode adds address-latch phases.
// RULE15: Setup and hold reset to maximum.
// RULE16: Latch strobe phases last 1 to 4 clocks.
// RULE17: Strobe width is 1 to 16 clocks.
// RULE18: Setup is 0 to 3 clocks.
// RULE19: One strobe per off-chip access only.
// RULE20: Memory answers while its strobe is low.
module emt_ext_mem_if (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [9:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        coreReq,
    input  wire        coreWe,
    input  wire        coreIs16,
    input  wire [15:0] coreDataPtr,
    input  wire [7:0]  coreIndirect,
    input  wire [7:0]  coreWdata,
    output reg         coreReady,
    output reg         coreDone,
    output reg  [7:0]  coreRdata,
    output reg  [7:0]  addrHiOut,
    output reg         addrHiOe,
    output reg  [7:0]  addrLoOut,
    output reg         addrLoOe,
    input  wire [7:0]  dataIn,
    output reg  [7:0]  dataOut,
    output reg         dataOe,
    output reg         rdN,
    output reg         wrN,
    output reg         ale,
    output reg         portSel
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [3:0] S_IDLE   = 4'h0;
    localparam [3:0] S_DECODE = 4'h1;
    localparam [3:0] S_ALEH   = 4'h2;
    localparam [3:0] S_ALEL   = 4'h3;
    localparam [3:0] S_SETUP  = 4'h4;
    localparam [3:0] S_STROBE = 4'h5;
    localparam [3:0] S_HOLD   = 4'h6;
    localparam [3:0] S_TAIL   = 4'h7;
    localparam [3:0] S_ONCHIP = 4'h8;
    localparam [3:0] S_ONWAIT = 4'h9;

    reg  [7:0]  timing_reg;
    reg  [7:0]  config_reg;
    reg  [7:0]  page_reg;
    reg  [3:0]  state_reg;
    reg  [3:0]  cnt_reg;
    reg         we_reg;
    reg  [15:0] eff_reg;
    reg         hiDrive_reg;
    reg  [7:0]  wdat_reg;
    reg         offchip_reg;
    reg         ramEn_reg;
    reg         ramWe_reg;

    wire [7:0]  ramRdata;
    wire [1:0]  opMode   = config_reg[`EMT_MODE_HI:`EMT_MODE_LO];
    wire        muxMode  = ~config_reg[`EMT_MUX_BIT];
    wire [1:0]  aleField = config_reg[`EMT_ALE_HI:`EMT_ALE_LO];
    wire [1:0]  setupFld = timing_reg[`EMT_AS_HI:`EMT_AS_LO];
    wire [3:0]  strobeFld = timing_reg[`EMT_WR_HI:`EMT_WR_LO];
    wire [1:0]  holdFld  = timing_reg[`EMT_AH_HI:`EMT_AH_LO];
    wire        wbHit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [7:0]  wbIdx    = wb_adr_i[`EMT_IDX_HI:`EMT_IDX_LO];

    // ----------------------------------------------------------------
    // Address decision
    // ----------------------------------------------------------------
    reg  [15:0] effAddr;
    reg         goOff;
    reg         hiDrive;

    always @* begin
        effAddr = coreIs16 ? coreDataPtr : {page_reg, coreIndirect}; // see RULE3 // see RULE4
        goOff   = 1'b0;
        hiDrive = 1'b0;
        case (opMode)
            `EMT_MODE_INT: begin
                goOff = 1'b0; // see RULE1
            end
            `EMT_MODE_SPLIT: begin
                goOff   = (effAddr[15:12] != `EMT_ONCHIP_TOP); // see RULE5 // see RULE6
                hiDrive = coreIs16; // see RULE6 // see RULE7
            end
            `EMT_MODE_BANK: begin
                goOff   = (effAddr[15:12] != `EMT_ONCHIP_TOP); // see RULE8
                hiDrive = 1'b1; // see RULE7 // see RULE8
            end
            `EMT_MODE_EXT: begin
                goOff   = 1'b1; // see RULE9
                hiDrive = coreIs16; // see RULE10 // see RULE11
            end
            default: begin
                goOff = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (sys_rst) begin
            timing_reg <= `EMT_TIMING_RST; // see RULE15
            config_reg <= `EMT_CONFIG_RST;
            page_reg   <= `EMT_PAGE_RST;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
            portSel    <= 1'b0;
        end else begin
            wb_ack_o <= wbHit;
            wb_dat_o <= 32'h0000_0000;
            if (wbHit && wb_we_i && wb_sel_i[0]) begin
                case (wbIdx)
                    `EMT_IDX_TIMING: timing_reg <= wb_dat_i[7:0]; // see RULE12
                    `EMT_IDX_CONFIG: config_reg <= wb_dat_i[7:0] & `EMT_CFG_MASK;
                    `EMT_IDX_PAGE:   page_reg   <= wb_dat_i[7:0];
                    default: begin
                    end
                endcase
            end
            if (wbHit && !wb_we_i) begin
                case (wbIdx)
                    `EMT_IDX_TIMING: wb_dat_o <= {24'h00_0000, timing_reg};
                    `EMT_IDX_CONFIG: wb_dat_o <= {24'h00_0000, config_reg};
                    `EMT_IDX_PAGE:   wb_dat_o <= {24'h00_0000, page_reg};
                    `EMT_IDX_STATUS: wb_dat_o <= {30'h0000_0000, offchip_reg, ~coreReady};
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
            portSel <= config_reg[`EMT_PSEL_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Access sequencer
    // ----------------------------------------------------------------
    // Timing fields are read live; software should not retune them
    // while an access is running.
    always @(posedge mclk) begin
        if (sys_rst) begin
            state_reg   <= S_IDLE;
            cnt_reg     <= `EMT_CNT_ZERO;
            we_reg      <= 1'b0;
            eff_reg     <= 16'h0000;
            hiDrive_reg <= 1'b0;
            wdat_reg    <= 8'h00;
            offchip_reg <= 1'b0;
            ramEn_reg   <= 1'b0;
            ramWe_reg   <= 1'b0;
            coreReady   <= 1'b0;
            coreDone    <= 1'b0;
            coreRdata   <= 8'h00;
            addrHiOut   <= 8'h00;
            addrHiOe    <= 1'b0;
            addrLoOut   <= 8'h00;
            addrLoOe    <= 1'b0;
            dataOut     <= 8'h00;
            dataOe      <= 1'b0;
            rdN         <= 1'b1;
            wrN         <= 1'b1;
            ale         <= 1'b0;
        end else begin
            coreDone  <= 1'b0;
            ramEn_reg <= 1'b0;
            ramWe_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    coreReady <= 1'b1;
                    if (coreReq && coreReady) begin
                        coreReady   <= 1'b0;
                        we_reg      <= coreWe;
                        eff_reg     <= effAddr;
                        hiDrive_reg <= hiDrive;
                        wdat_reg    <= coreWdata;
                        offchip_reg <= goOff;
                        state_reg   <= S_DECODE;
                    end
                end
                S_DECODE: begin
                    if (!offchip_reg) begin
                        ramEn_reg <= 1'b1; // see RULE19
                        ramWe_reg <= we_reg;
                        state_reg <= S_ONCHIP;
                    end else begin
                        addrHiOut <= eff_reg[15:8];
                        addrHiOe  <= hiDrive_reg; // see RULE6 // see RULE10
                        if (muxMode) begin
                            dataOut   <= eff_reg[7:0];
                            dataOe    <= 1'b1;
                            ale       <= 1'b1;
                            cnt_reg   <= {2'b00, aleField}; // see RULE14 // see RULE16
                            state_reg <= S_ALEH;
                        end else begin
                            addrLoOut <= eff_reg[7:0];
                            addrLoOe  <= 1'b1;
                            dataOut   <= wdat_reg;
                            dataOe    <= we_reg;
                            if (setupFld != 2'b00) begin
                                cnt_reg   <= {2'b00, setupFld} - `EMT_CNT_ONE; // see RULE18
                                state_reg <= S_SETUP;
                            end else begin
                                rdN       <= we_reg; // see RULE19
                                wrN       <= ~we_reg;
                                cnt_reg   <= strobeFld; // see RULE17
                                state_reg <= S_STROBE;
                            end
                        end
                    end
                end
                S_ALEH: begin
                    if (cnt_reg != `EMT_CNT_ZERO) begin
                        cnt_reg <= cnt_reg - `EMT_CNT_ONE;
                    end else begin
                        ale       <= 1'b0;
                        cnt_reg   <= {2'b00, aleField}; // see RULE16
                        state_reg <= S_ALEL;
                    end
                end
                S_ALEL: begin
                    if (cnt_reg != `EMT_CNT_ZERO) begin
                        cnt_reg <= cnt_reg - `EMT_CNT_ONE;
                    end else begin
                        dataOut <= wdat_reg;
                        dataOe  <= we_reg;
                        if (setupFld != 2'b00) begin
                            cnt_reg   <= {2'b00, setupFld} - `EMT_CNT_ONE; // see RULE18
                            state_reg <= S_SETUP;
                        end else begin
                            rdN       <= we_reg; // see RULE19
                            wrN       <= ~we_reg;
                            cnt_reg   <= strobeFld; // see RULE17
                            state_reg <= S_STROBE;
                        end
                    end
                end
                S_SETUP: begin
                    if (cnt_reg != `EMT_CNT_ZERO) begin
                        cnt_reg <= cnt_reg - `EMT_CNT_ONE;
                    end else begin
                        rdN       <= we_reg; // see RULE19
                        wrN       <= ~we_reg;
                        cnt_reg   <= strobeFld; // see RULE17
                        state_reg <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    if (cnt_reg != `EMT_CNT_ZERO) begin
                        cnt_reg <= cnt_reg - `EMT_CNT_ONE;
                    end else begin
                        // Sampled on the edge that ends the strobe
                        if (!we_reg) begin
                            coreRdata <= dataIn; // see RULE20
                        end
                        rdN <= 1'b1;
                        wrN <= 1'b1;
                        if (holdFld != 2'b00) begin
                            cnt_reg   <= {2'b00, holdFld} - `EMT_CNT_ONE;
                            state_reg <= S_HOLD;
                        end else begin
                            addrHiOe  <= 1'b0;
                            addrLoOe  <= 1'b0;
                            dataOe    <= 1'b0;
                            cnt_reg   <= `EMT_TAIL_CYC - `EMT_CNT_ONE; // see RULE13
                            state_reg <= S_TAIL;
                        end
                    end
                end
                S_HOLD: begin
                    if (cnt_reg != `EMT_CNT_ZERO) begin
                        cnt_reg <= cnt_reg - `EMT_CNT_ONE;
                    end else begin
                        // Bus released before the tail so port latches regain pins
                        addrHiOe  <= 1'b0;
                        addrLoOe  <= 1'b0;
                        dataOe    <= 1'b0;
                        cnt_reg   <= `EMT_TAIL_CYC - `EMT_CNT_ONE; // see RULE13
                        state_reg <= S_TAIL;
                    end
                end
                S_TAIL: begin
                    if (cnt_reg != `EMT_CNT_ZERO) begin
                        cnt_reg <= cnt_reg - `EMT_CNT_ONE;
                    end else begin
                        coreDone  <= 1'b1; // see RULE13
                        coreReady <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                S_ONCHIP: begin
                    state_reg <= S_ONWAIT;
                end
                S_ONWAIT: begin
                    if (!we_reg) begin
                        coreRdata <= ramRdata;
                    end
                    coreDone  <= 1'b1;
                    coreReady <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // On-chip data RAM
    // ----------------------------------------------------------------
    // Only the low twelve bits reach the array, so upper pages alias
    emt_data_ram_space uRam (
        .mclk  (mclk),
        .en    (ramEn_reg),
        .we    (ramWe_reg),
        .addr  (eff_reg[`EMT_RAM_AW-1:0]), // see RULE2
        .wdata (wdat_reg),
        .rdata (ramRdata)
    );

endmodule // emt_ext_mem_if

`default_nettype wire

//--- rtl/emt_consts.vh
`ifndef EMT_CONSTS_VH
`define EMT_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define EMT_IDX_TIMING   8'hA1
`define EMT_IDX_CONFIG   8'hA3
`define EMT_IDX_STATUS   8'hA4
`define EMT_IDX_PAGE     8'hAF
`define EMT_IDX_HI       9
`define EMT_IDX_LO       2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EMT_TIMING_RST   8'hFF
`define EMT_CONFIG_RST   8'h03
`define EMT_PAGE_RST     8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EMT_AS_HI        7
`define EMT_AS_LO        6
`define EMT_WR_HI        5
`define EMT_WR_LO        2
`define EMT_AH_HI        1
`define EMT_AH_LO        0
`define EMT_PSEL_BIT     5
`define EMT_MUX_BIT      4
`define EMT_MODE_HI      3
`define EMT_MODE_LO      2
`define EMT_ALE_HI       1
`define EMT_ALE_LO       0
`define EMT_CFG_MASK     8'h3F

// ----------------------------------------------------------------
// Operating modes and space layout
// ----------------------------------------------------------------
`define EMT_MODE_INT     2'h0
`define EMT_MODE_SPLIT   2'h1
`define EMT_MODE_BANK    2'h2
`define EMT_MODE_EXT     2'h3
`define EMT_ONCHIP_TOP   4'h0
`define EMT_RAM_AW       12
`define EMT_RAM_DEPTH    4096

// ----------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------
`define EMT_TAIL_CYC     4'h3
`define EMT_CNT_ONE      4'h1
`define EMT_CNT_ZERO     4'h0

`endif

//--- rtl/emt_data_ram_space.v
`timescale 1ns/1ps
`default_nettype none
`include "emt_consts.vh"

module emt_data_ram_space (
    input  wire                    mclk,
    input  wire                    en,
    input  wire                    we,
    input  wire [`EMT_RAM_AW-1:0]  addr,
    input  wire [7:0]              wdata,
    output reg  [7:0]              rdata
);

    reg [7:0] memArray [0:`EMT_RAM_DEPTH-1];

    // ----------------------------------------------------------------
    // Single port, read data one cycle after enable
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (en) begin
            if (we) begin
                memArray[addr] <= wdata;
            end
            rdata <= memArray[addr];
        end
    end

endmodule // emt_data_ram_space

`default_nettype wire

//--- test/emt_ext_mem_if_checker.sv
`timescale 1ns/1ps
`default_nettype none
module emt_ext_mem_if_checker (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        coreReq,
    input wire logic        coreReady,
    input wire logic        coreDone,
    input wire logic        dataOe,
    input wire logic        rdN,
    input wire logic        wrN,
    input wire logic        ale
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence s_take;
        coreReq && coreReady;
    endsequence
    sequence s_strobeFall;
        $fell(rdN) || $fell(wrN);
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_oneStrobe; !(!rdN && !wrN); endproperty
    property p_idleQuiet; coreReady |-> rdN && wrN; endproperty
    property p_takeBusy; s_take |=> !coreReady; endproperty
    // Tail after a strobe is fixed, so done cannot follow within four cycles
    property p_tailMin; s_strobeFall |-> !coreDone [*4]; endproperty
    property p_aleCarries; ale |-> dataOe && rdN && wrN; endproperty
    property p_readTurn; !rdN |-> !dataOe; endproperty
    property p_writeData; !wrN |-> dataOe; endproperty
    property p_donePulse; coreDone |=> !coreDone; endproperty
    property p_ackNext; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ackData; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_oneStrobe: assert property (p_oneStrobe) else $error("both strobes low");
    a_idleQuiet: assert property (p_idleQuiet) else $error("strobe while idle");
    a_takeBusy: assert property (p_takeBusy) else $error("ready after take");
    a_tailMin: assert property (p_tailMin) else $error("access too short");
    a_aleCarries: assert property (p_aleCarries) else $error("latch phase bad");
    a_readTurn: assert property (p_readTurn) else $error("data driven on read");
    a_writeData: assert property (p_writeData) else $error("write data absent");
    a_donePulse: assert property (p_donePulse) else $error("done too long");
    a_ackNext: assert property (p_ackNext) else $error("no bus ack");
    a_ackData: assert property (p_ackData) else $error("upper read bits set");
endmodule // emt_ext_mem_if_checker
bind emt_ext_mem_if emt_ext_mem_if_checker u_emt_ext_mem_if_checker (
    .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .coreReq(coreReq), .coreReady(coreReady),
    .coreDone(coreDone), .dataOe(dataOe), .rdN(rdN), .wrN(wrN), .ale(ale)
);
`default_nettype wire

//--- test/emt_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module emt_sram_model (
    input  wire logic        mclk,
    input  wire logic [7:0]  addrHiOut,
    input  wire logic        addrHiOe,
    input  wire logic [7:0]  addrLoOut,
    input  wire logic        addrLoOe,
    input  wire logic [7:0]  dataOut,
    input  wire logic        rdN,
    input  wire logic        wrN,
    input  wire logic        ale,
    input  wire logic [7:0]  hiPark,
    output logic      [7:0]  dataIn,
    output logic      [15:0] busAddr
);
    logic [7:0] mem [0:65535];
    logic [7:0] loLatch = 8'h00;
    logic [7:0] lastRd = 8'h00;
    // Undriven upper byte keeps the parked port value
    assign busAddr = {addrHiOe ? addrHiOut : hiPark, addrLoOe ? addrLoOut : loLatch};
    // Released bus shows the inverse of the last value so a stale sample fails
    assign dataIn = (rdN == 1'b0) ? mem[busAddr] : ~lastRd;
    always @(posedge mclk) begin
        if (ale == 1'b1)
            loLatch <= dataOut;
        if (rdN == 1'b0)
            lastRd <= mem[busAddr];
        if (wrN == 1'b0)
            mem[busAddr] <= dataOut;
    end
endmodule // emt_sram_model
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  tc;
        logic        s16;
        logic        we;
        logic [15:0] adr;
        logic [7:0]  dat;
    } emt_row_t;
    logic        mclk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        coreReq, coreWe, coreIs16, coreReady, coreDone;
    logic [15:0] coreDataPtr, busAddr;
    logic [7:0]  coreIndirect, coreWdata, coreRdata, addrHiOut, addrLoOut, dataIn, dataOut;
    logic        addrHiOe, addrLoOe, dataOe, rdN, wrN, ale, portSel;
    int          err_total = 0;
    int          check_count = 0;
    emt_row_t    rows [18];
    emt_ext_mem_if u_emt_ext_mem_if (
        .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .coreReq(coreReq), .coreWe(coreWe),
        .coreIs16(coreIs16), .coreDataPtr(coreDataPtr), .coreIndirect(coreIndirect),
        .coreWdata(coreWdata), .coreReady(coreReady), .coreDone(coreDone),
        .coreRdata(coreRdata), .addrHiOut(addrHiOut), .addrHiOe(addrHiOe),
        .addrLoOut(addrLoOut), .addrLoOe(addrLoOe), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .rdN(rdN), .wrN(wrN), .ale(ale), .portSel(portSel)
    );
    emt_sram_model u_emt_sram_model (
        .mclk(mclk), .addrHiOut(addrHiOut), .addrHiOe(addrHiOe), .addrLoOut(addrLoOut),
        .addrLoOe(addrLoOe), .dataOut(dataOut), .rdN(rdN), .wrN(wrN), .ale(ale),
        .hiPark(8'h5A), .dataIn(dataIn), .busAddr(busAddr)
    );
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic s,
                      output logic [31:0] r);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        wb_sel_i <= {4{s}};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 40) begin
            err_total++;
            tally_and_finish();
        end
        @(posedge mclk);
    endtask
    // Counts cycles from the take edge; strobe and latch cycles counted on the way
    task automatic core(input emt_row_t r, output int n, output int strb, output int aleN,
                        output logic [15:0] ba);
        coreReq <= 1'b1;
        coreWe <= r.we;
        coreIs16 <= r.s16;
        coreDataPtr <= r.adr;
        coreIndirect <= r.adr[7:0];
        coreWdata <= r.dat;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (coreReady !== 1'b1 && n < 40);
        coreReq <= 1'b0;
        // A request never taken skips the wait and lands in the timeout below
        n = (n >= 40) ? 60 : 0;
        strb = 0;
        aleN = 0;
        ba = 16'h0000;
        while (n < 60) begin
            @(posedge mclk);
            if (coreDone === 1'b1)
                break;
            if (rdN === 1'b0 || wrN === 1'b0) begin
                strb++;
                ba = busAddr;
            end
            if (ale === 1'b1)
                aleN++;
            n++;
        end
        if (n >= 60) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        logic [31:0] rd;
        logic [15:0] ba;
        logic [1:0]  mode;
        logic        off, mux;
        int          n, strb, aleN, expW, expA;
        rows = '{
            '{8'h10, 8'h00, 1'h1, 1'h1, 16'h1005, 8'hA1},
            '{8'h10, 8'h00, 1'h1, 1'h0, 16'h2005, 8'hA1},
            '{8'h10, 8'h00, 1'h0, 1'h0, 16'h3005, 8'hA1},
            '{8'h14, 8'h00, 1'h1, 1'h1, 16'h0FFF, 8'hB2},
            '{8'h14, 8'h00, 1'h1, 1'h1, 16'h1000, 8'hC3},
            '{8'h14, 8'h00, 1'h0, 1'h1, 16'h1234, 8'hD4},
            '{8'h18, 8'h00, 1'h0, 1'h1, 16'h1234, 8'hE5},
            '{8'h18, 8'h00, 1'h1, 1'h0, 16'h0FFF, 8'hB2},
            '{8'h1C, 8'h00, 1'h1, 1'h1, 16'h0FFF, 8'hF6},
            '{8'h1C, 8'h00, 1'h0, 1'h0, 16'h0034, 8'hD4},
            '{8'h1C, 8'h00, 1'h1, 1'h0, 16'h1000, 8'hC3},
            '{8'h18, 8'h00, 1'h1, 1'h0, 16'h0FFF, 8'hB2},
            '{8'h14, 8'hFF, 1'h1, 1'h0, 16'h1234, 8'hE5},
            '{8'h14, 8'h44, 1'h1, 1'h0, 16'h1000, 8'hC3},
            '{8'h04, 8'h00, 1'h1, 1'h0, 16'h1000, 8'hC3},
            '{8'h07, 8'h00, 1'h1, 1'h0, 16'h1234, 8'hE5},
            '{8'h05, 8'h00, 1'h1, 1'h1, 16'h2000, 8'h5C},
            '{8'h14, 8'h00, 1'h1, 1'h0, 16'h2000, 8'h5C}};
        {wb_cyc_i, wb_stb_i, wb_we_i, coreReq, coreWe, coreIs16} = 6'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 46'h0;
        {coreDataPtr, coreIndirect, coreWdata} = 32'h0;
        sys_rst = 1'b1;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        wb(1'h0, 10'h284, 8'h00, 1'h1, rd);
        check(rd, 32'h000000FF);
        wb(1'h0, 10'h2BC, 8'h00, 1'h1, rd);
        check(rd, 32'h00000000);
        wb(1'h1, 10'h000, 8'h77, 1'h1, rd);
        wb(1'h0, 10'h000, 8'h00, 1'h1, rd);
        check(rd, 32'h00000000);
        wb(1'h1, 10'h284, 8'h12, 1'h0, rd);
        wb(1'h1, 10'h284, 8'h9E, 1'h1, rd);
        wb(1'h0, 10'h284, 8'h00, 1'h1, rd);
        check(rd, 32'h0000009E);
        foreach (rows[i]) begin
            wb(1'h1, 10'h28C, rows[i].cfg, 1'h1, rd);
            wb(1'h1, 10'h284, rows[i].tc, 1'h1, rd);
            wb(1'h1, 10'h2BC, rows[i].adr[15:8], 1'h1, rd);
            mode = rows[i].cfg[3:2];
            mux = !rows[i].cfg[4];
            off = mode == 2'h3 || (mode != 2'h0 && rows[i].adr >= 16'h1000);
            expW = rows[i].tc[5:2] + 1;
            expA = mux ? 2 * (rows[i].cfg[1:0] + 1) : 0;
            core(rows[i], n, strb, aleN, ba);
            check(n, off ? 4 + expA + rows[i].tc[7:6] + expW + rows[i].tc[1:0] : 3);
            check(strb, off ? expW : 0);
            check(aleN, off ? expA / 2 : 0);
            if (off)
                check(ba, (rows[i].s16 || mode == 2'h2) ? rows[i].adr :
                          {8'h5A, rows[i].adr[7:0]});
            if (!rows[i].we)
                check(coreRdata, rows[i].dat);
        end
        wb(1'h0, 10'h290, 8'h00, 1'h1, rd);
        check(rd, 32'h00000002);
        wb(1'h1, 10'h28C, 8'h23, 1'h1, rd);
        check(portSel, 1'h1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check({portSel, rdN, wrN}, 32'h00000003);
        wb(1'h0, 10'h284, 8'h00, 1'h1, rd);
        check(rd, 32'h000000FF);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
